/* uif_checker.sv */
// Concurrent checks on the interrupt and line format block.
// Assumes it is bound to uif_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module uif_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic tx_serial_raw,
  input wire logic tx_serial,
  input wire uif_pkg::uif_format_t format,
  input wire logic fifo_enable
);
  import uif_pkg::*;
  // ----------------------------------------
  // Identification read data phase
  // ----------------------------------------
  logic rd_iid;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_iid <= 1'b0;
    end else begin
      rd_iid <= hsel && hready && htrans[1] && !hwrite && haddr == 8'h00;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_break_low: assert property (
    format.break_on |=> !tx_serial) else $error("break not held low");
  a_raw_pass: assert property (
    !format.break_on |=> tx_serial == $past(tx_serial_raw))
    else $error("serial output not passed through");
  a_force_on: assert property (
    format.parity_forced |-> format.parity_on)
    else $error("forced parity without parity");
  a_force_value: assert property (
    format.parity_value_forced == !format.parity_even)
    else $error("forced parity value wrong");
  a_word_range: assert property (
    format.data_bits inside {[4'h5:4'h8]}) else $error("bad word length");
  a_stop_len: assert property (
    format.stop_half_bits != 2'h2 |->
    format.stop_half_bits == (format.data_bits == 4'h5 ? 2'h3 : 2'h0))
    else $error("stop length wrong");
  a_iid_upper: assert property (
    rd_iid |-> hrdata[31:4] == {24'h0, fifo_enable, fifo_enable, 2'h0})
    else $error("identification upper bits wrong");
  a_iid_code: assert property (
    rd_iid |-> hrdata[5:0] inside {6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h01})
    else $error("identification code illegal");
endmodule
`default_nettype wire

/* uif_far_model.sv */
// Channel datapath model: event pulses on request, random serial bits.
// Assumes the same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module uif_far_model (
  input wire logic clock,
  input wire logic rstn,
  input wire uif_pkg::uif_events_t req,
  output uif_pkg::uif_events_t events,
  output logic tx_serial_raw
);
  import uif_pkg::*;
  initial begin
    events = '0;
    tx_serial_raw = 1'b1;
  end
  // Raw line is redrawn at random each cycle so a stale pass-through is seen
  always @(posedge clock) begin
    events <= rstn ? req : '0;
    tx_serial_raw <= rstn ? 1'($urandom) : 1'b1;
  end
endmodule
`default_nettype wire

/* uif_pkg.sv */
// Types shared by the interrupt-identification and line-format block.
// Assumes uif_regs.svh supplies the numeric constants.
package uif_pkg;
  typedef enum logic [2:0] {
    UIF_SRC_LINE,
    UIF_SRC_RXDATA,
    UIF_SRC_RXTMO,
    UIF_SRC_TXEMPTY,
    UIF_SRC_MODEM,
    UIF_SRC_NONE
  } uif_src_t;

  // Character format handed to the shift logic
  typedef struct packed {
    logic [3:0] data_bits;
    logic parity_on;
    logic parity_value_forced;
    logic parity_forced;
    logic parity_even;
    logic [1:0] stop_half_bits;
    logic break_on;
    logic divisor_access;
  } uif_format_t;

  // One-cycle event pulses from the channel datapath
  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic rx_timeout;
    logic tx_empty;
    logic modem;
  } uif_events_t;
endpackage

/* uif_regs.svh */
// Register offsets, field positions, reset values for the channel
// interrupt-identification and line-format block.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
`ifndef UIF_REGS_SVH
`define UIF_REGS_SVH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define UIF_OFF_IID 8'h00
`define UIF_OFF_LFC 8'h04
`define UIF_OFF_FIFO 8'h08
`define UIF_OFF_SRC 8'h0C
`define UIF_OFF_ENA 8'h10

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define UIF_LFC_DLAB 7
`define UIF_LFC_BREAK 6
`define UIF_LFC_FORCE 5
`define UIF_LFC_EVEN 4
`define UIF_LFC_PAREN 3
`define UIF_LFC_STOP 2
`define UIF_FIFO_EN 0
`define UIF_CODE_LINE 6'h06
`define UIF_CODE_RXDATA 6'h04
`define UIF_CODE_RXTMO 6'h0C
`define UIF_CODE_TXEMPTY 6'h02
`define UIF_CODE_MODEM 6'h00
`define UIF_CODE_NONE 6'h01

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UIF_LFC_RESET 8'h00
`define UIF_FIFO_RESET 8'h00
`define UIF_ENA_RESET 8'h00

`endif

/* uif_top.sv */
// Interrupt identification and character-format control for one serial
// channel, reached over AHB-Lite. Event pulses come from the same clock.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uif_regs.svh"

// Operation
// - Reading the identification register returns the code latched for the highest pending source.
// - That read clears only the reported source; lower ones show next.
// - While a report is unserviced, no other source is acknowledged.
// - Line status is level 1, code 000110.
// - Received data available is level 2, code 000100.
// - Receive timeout is level 2, code 001100.
// - Transmit holding empty is level 3, code 000010.
// - Modem status is level 4, code 000000.
// - Bits 7:6 show FIFO enable, bits 5:4 read zero.
// - Bit 0 reads zero when pending, one when idle.
// - Format bit 7 opens divisor and enhanced access, default off.
// - Format bit 6 holds serial output low for a break.
// - Format bit 3 enables parity generation and checking.
// - Format bit 4 picks odd when zero, even when one.
// - Format bit 5 forces parity to the inverse of bit 4.
// - Format bit 2 gives one, one and a half, or two stops.
// - Format bits 1:0 choose five to eight data bits.
// - FIFO enable bit enables both FIFOs and shows in bits 7:6.
module uif_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire uif_pkg::uif_events_t events,
  input wire logic tx_serial_raw,
  output logic tx_serial,
  output uif_pkg::uif_format_t format,
  output logic fifo_enable,
  output logic irq
);
  import uif_pkg::*;

  // ----------------------------------------
  // Register map (byte offsets, one aligned word each)
  // ----------------------------------------
  // 0x00 identification: RO, reported source code and FIFO flags
  // 0x04 line format: RW, character format, break, divisor access
  // 0x08 FIFO control: RW, bit 0 enables; other bits need it set
  // 0x0C raw pending: RO, sticky source flags, bit 0 line status
  // 0x10 source enable: RW, one mask bit per source, all off at reset
  // Unmapped offsets read zero and drop writes. There are no wait
  // states, so hreadyout is tied high and every response is OKAY.
  // hsize is not checked: only whole-word access is supported, and a
  // narrow write still lands its low byte.
  // Only the low byte of a word carries meaning; upper bits read zero.

  // ----------------------------------------
  // Bus slave address phase capture
  // ----------------------------------------
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic take;

  // Read data is steered from the registered address phase, so it is
  // valid for exactly one data phase and zero in every other cycle.
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  logic [7:0] line_format_control;
  logic [7:0] fifo_control;
  logic [4:0] source_enable;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      line_format_control <= `UIF_LFC_RESET;
      fifo_control <= `UIF_FIFO_RESET;
      source_enable <= 5'(`UIF_ENA_RESET);
    end else if (wr_pend) begin
      case (addr_q)
        `UIF_OFF_LFC: begin
          line_format_control <= hwdata[7:0];
        end
        `UIF_OFF_FIFO: begin
          // Other bits only take effect with the enable written as one;
          // writing the enable as zero drops the whole register.
          if (hwdata[`UIF_FIFO_EN]) begin
            fifo_control <= hwdata[7:0];
          end else begin
            fifo_control <= `UIF_FIFO_RESET;
          end
        end
        `UIF_OFF_ENA: begin
          source_enable <= hwdata[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  assign fifo_enable = fifo_control[`UIF_FIFO_EN];

  // ----------------------------------------
  // Pending sources and priority
  // ----------------------------------------
  // Bit order: line, rx data, rx timeout, tx empty, modem
  logic [4:0] pending;
  logic [4:0] ev_vec;
  logic [4:0] live;
  uif_src_t top_src;
  uif_src_t reported;
  logic report_held;
  logic iid_read;

  assign ev_vec = {events.modem, events.tx_empty, events.rx_timeout,
                   events.rx_data, events.line_status};
  assign live = pending & source_enable;
  assign iid_read = rd_pend && (addr_q == `UIF_OFF_IID);

  // Priority is fixed by position: line status first, modem last. The
  // two level-two sources share a level; data is served ahead of the
  // timeout so a full receiver is drained before the idle report.
  function automatic uif_src_t pick_top(input logic [4:0] v);
    uif_src_t s;
    s = UIF_SRC_NONE;
    if (v[0]) begin
      s = UIF_SRC_LINE;
    end else if (v[1]) begin
      s = UIF_SRC_RXDATA;
    end else if (v[2]) begin
      s = UIF_SRC_RXTMO;
    end else if (v[3]) begin
      s = UIF_SRC_TXEMPTY;
    end else if (v[4]) begin
      s = UIF_SRC_MODEM;
    end
    return s;
  endfunction

  function automatic logic [5:0] src_code(input uif_src_t s);
    logic [5:0] c;
    case (s)
      UIF_SRC_LINE: begin
        c = `UIF_CODE_LINE;
      end
      UIF_SRC_RXDATA: begin
        c = `UIF_CODE_RXDATA;
      end
      UIF_SRC_RXTMO: begin
        c = `UIF_CODE_RXTMO;
      end
      UIF_SRC_TXEMPTY: begin
        c = `UIF_CODE_TXEMPTY;
      end
      UIF_SRC_MODEM: begin
        c = `UIF_CODE_MODEM;
      end
      default: begin
        c = `UIF_CODE_NONE;
      end
    endcase
    return c;
  endfunction

  assign top_src = pick_top(live);

  // Whether the latched source is still pending and enabled. A case
  // keeps the lookup inside the five flags even for the idle code.
  function automatic logic src_live(input uif_src_t s,
                                    input logic [4:0] v);
    logic r;
    r = 1'b0;
    case (s)
      UIF_SRC_LINE: r = v[0];
      UIF_SRC_RXDATA: r = v[1];
      UIF_SRC_RXTMO: r = v[2];
      UIF_SRC_TXEMPTY: r = v[3];
      UIF_SRC_MODEM: r = v[4];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic reported_live;
  assign reported_live = src_live(reported, live);

  // The report is frozen once latched, so a newly arriving higher source
  // cannot swap the code under a service routine.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      reported <= UIF_SRC_NONE;
      report_held <= 1'b0;
    end else if (iid_read) begin
      report_held <= 1'b0;
      reported <= UIF_SRC_NONE;
    end else if (!report_held && top_src != UIF_SRC_NONE) begin
      reported <= top_src;
      report_held <= 1'b1;
    end else if (report_held && !reported_live) begin
      // Source disabled or gone: release the report, so the code never
      // points at something that no longer pends.
      report_held <= 1'b0;
      reported <= UIF_SRC_NONE;
    end
  end

  // One-hot clear of the reported source on an identification read
  logic [4:0] clear_vec;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pend
      assign clear_vec[gi] = iid_read && report_held &&
                             (reported == uif_src_t'(3'(gi)));
      always_ff @(posedge clock) begin
        if (!rstn) begin
          pending[gi] <= 1'b0;
        end else if (ev_vec[gi]) begin
          // Set wins over the read-clear in the same cycle
          pending[gi] <= 1'b1;
        end else if (clear_vec[gi]) begin
          pending[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |live;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [5:0] iid_code;
  logic [7:0] iid_value;

  // The idle code stands whenever nothing is latched, so a released
  // source never reads back after its report was dropped.
  always_comb begin
    if (report_held) begin
      iid_code = src_code(reported);
    end else begin
      iid_code = `UIF_CODE_NONE;
    end
  end

  // Upper pair mirrors the FIFO enable; bits 5:4 are reserved zero
  assign iid_value = {{2{fifo_enable}}, 2'b00, iid_code[3:0]};

  always_comb begin
    hrdata = 32'h00000000;
    if (rd_pend) begin
      case (addr_q)
        `UIF_OFF_IID: begin
          hrdata = {24'h000000, iid_value};
        end
        `UIF_OFF_LFC: begin
          hrdata = {24'h000000, line_format_control};
        end
        `UIF_OFF_FIFO: begin
          hrdata = {24'h000000, fifo_control};
        end
        `UIF_OFF_SRC: begin
          hrdata = {27'h0000000, pending};
        end
        `UIF_OFF_ENA: begin
          hrdata = {27'h0000000, source_enable};
        end
        default: begin
          hrdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Character format decode
  // ----------------------------------------
  logic [1:0] wl;
  assign wl = line_format_control[1:0];

  always_comb begin
    format.data_bits = 4'(wl) + 4'h5;
    format.parity_on = line_format_control[`UIF_LFC_PAREN];
    format.parity_even = line_format_control[`UIF_LFC_EVEN];
    format.parity_forced = line_format_control[`UIF_LFC_PAREN] &&
                           line_format_control[`UIF_LFC_FORCE];
    format.parity_value_forced = !line_format_control[`UIF_LFC_EVEN];
    // Stop length is counted in half bit times: 2 is one stop, 3 is one
    // and a half, and the field wraps to 0 for two stops (four halves).
    if (!line_format_control[`UIF_LFC_STOP]) begin
      format.stop_half_bits = 2'h2;
    end else if (wl == 2'h0) begin
      format.stop_half_bits = 2'h3;
    end else begin
      format.stop_half_bits = 2'h0; // (0 means four halves)
    end
    format.break_on = line_format_control[`UIF_LFC_BREAK];
    format.divisor_access = line_format_control[`UIF_LFC_DLAB];
  end

  // ----------------------------------------
  // Break output
  // ----------------------------------------
  // Break overrides whatever the shifter drives. It is applied behind a
  // flop so the line changes one cycle after the write, the same delay
  // as the pass-through, and the line idles high out of reset.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_serial <= 1'b1;
    end else begin
      tx_serial <= line_format_control[`UIF_LFC_BREAK] ? 1'b0 : tx_serial_raw;
    end
  end
endmodule
`default_nettype wire

/* uif_top_tb.sv */
// Self-checking bench for the interrupt and line format block.
// Assumes uif_top, uif_far_model and uif_checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "uif_regs.svh"
module uif_top_tb;
  import uif_pkg::*;
  logic clock, rstn, hsel, hwrite, hready, hresp;
  logic tx_serial_raw, tx_serial, fifo_enable, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  uif_events_t events, req;
  uif_format_t format;
  int bad_count = 0;
  int checked = 0;
  localparam logic [5:0] codes [5] = '{6'h00, 6'h02, 6'h0C, 6'h04, 6'h06};
  uif_top i_dut(.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .events(events), .tx_serial_raw(tx_serial_raw), .tx_serial(tx_serial),
    .format(format), .fifo_enable(fifo_enable), .irq(irq));
  uif_far_model i_far(.clock(clock), .rstn(rstn), .req(req),
    .events(events), .tx_serial_raw(tx_serial_raw));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ----------------------------------------
  // Bus, compare and expectation helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic fire(input uif_events_t e);
    req <= e;
    @(posedge clock);
    req <= '0;
    repeat (3) @(posedge clock);
  endtask
  function automatic uif_format_t exp_fmt(input logic [7:0] v);
    uif_format_t f;
    f.data_bits = 4'h5 + {2'h0, v[1:0]};
    f.parity_on = v[3];
    f.parity_value_forced = ~v[4];
    f.parity_forced = v[3] & v[5];
    f.parity_even = v[4];
    f.stop_half_bits = !v[2] ? 2'h2 : (v[1:0] == 2'h0 ? 2'h3 : 2'h0);
    f.break_on = v[6];
    f.divisor_access = v[7];
    return f;
  endfunction
  // Highest pending code, and that source taken off the model's set
  function automatic logic [31:0] top_code(inout logic [4:0] p);
    for (int k = 4; k >= 0; k--) begin
      if (p[k]) begin
        p[k] = 1'b0;
        return {26'h0, codes[k]};
      end
    end
    return 32'h01;
  endfunction
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [4:0] p;
    logic [31:0] c;
    void'($urandom(32'h13a36b59));
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    req = '0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    chk(32'(format), 32'(exp_fmt(8'h00)));
    chk({30'h0, tx_serial, irq}, 32'h2);
    rd(`UIF_OFF_IID, 32'h01);
    rd(`UIF_OFF_LFC, 32'h00);
    $display("reset test done");
    for (int i = 0; i < 256; i++) begin
      wr(`UIF_OFF_LFC, 32'(i));
      rd(`UIF_OFF_LFC, 32'(i));
      chk(32'(format), 32'(exp_fmt(8'(i))));
      if (i[6]) chk({31'h0, tx_serial}, 32'h0);
    end
    wr(`UIF_OFF_LFC, 32'h0);
    $display("format test done");
    wr(`UIF_OFF_ENA, 32'h1F);
    for (int r = 0; r < 12; r++) begin
      p = (r == 0) ? 5'h1F : 5'($urandom);
      fire(p);
      chk({31'h0, irq}, {31'h0, |p});
      repeat (6) begin
        c = top_code(p);
        rd(`UIF_OFF_IID, c);
        @(posedge clock);
      end
    end
    fire(5'h08);
    fire(5'h10);
    rd(`UIF_OFF_IID, 32'h04);
    @(posedge clock);
    rd(`UIF_OFF_IID, 32'h06);
    $display("priority test done");
    wr(`UIF_OFF_FIFO, 32'h1);
    @(posedge clock);
    chk({31'h0, fifo_enable}, 32'h1);
    rd(`UIF_OFF_IID, 32'hC1);
    wr(`UIF_OFF_FIFO, 32'h0);
    wr(`UIF_OFF_ENA, 32'h0);
    fire(5'h1F);
    chk({31'h0, irq}, 32'h0);
    rd(`UIF_OFF_IID, 32'h01);
    rd(`UIF_OFF_SRC, 32'h1F);
    rd(8'h40, 32'h0);
    $display("fifo and enable test done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
endmodule
bind uif_top uif_checker i_chk(.clock(clock), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .tx_serial_raw(tx_serial_raw), .tx_serial(tx_serial),
  .format(format), .fifo_enable(fifo_enable));
`default_nettype wire
